/* File: design/dcw_config_loader.sv */
// device-options configuration loader with pin ownership and wishbone readback
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps

// Summary of operation
// - upper sixteen bits carry a free user identifier, readable, no other effect.
// - bit 15 set gives the bus-power switch pin to USB, else port.
// - bit 14 set gives the identification pin to USB, else port.
// - bit 4 set routes first I2C to default pins, clear to alternate.
// - bit 3 set runs secondary oscillator normal power, clear high power.
module dcw_config_loader
   import dcw_pkg::*;
(
   input  wire logic         CLK_IN,
   input  wire logic         RST_IN,
   input  wire logic         WB_CYC_IN,
   input  wire logic         WB_STB_IN,
   input  wire logic         WB_WE_IN,
   input  wire logic [15:0]  WB_ADR_IN,
   input  wire logic [3:0]   WB_SEL_IN,
   input  wire logic [31:0]  WB_DAT_IN,
   output logic      [31:0]  WB_DAT_OUT,
   output logic              WB_ACK_OUT,
   input  wire dcw_words_t   NV_WORDS_IN,
   input  wire logic         USB_BUS_POWER_IN,
   input  wire logic         PORT_BUS_POWER_IN,
   output logic              BUS_POWER_SWITCH_OUT,
   input  wire logic         USB_ID_PIN_IN,
   output logic              USB_ID_OUT,
   output logic              PORT_ID_OUT,
   input  wire dcw_i2c_drv_t I2C_DRV_IN,
   output dcw_i2c_rx_t       I2C_RX_OUT,
   input  wire dcw_i2c_rx_t  DEF_PINS_IN,
   output dcw_i2c_drv_t      DEF_PINS_OUT,
   input  wire dcw_i2c_rx_t  ALT_PINS_IN,
   output dcw_i2c_drv_t      ALT_PINS_OUT,
   output logic      [15:0]  USER_ID_OUT,
   output logic              SECONDARY_OSCILLATOR_HIGH_POWER_OUT,
   output logic              OPTS_VALID_OUT
);

   // -------------------------------------------------------------
   // configuration word shadow
   // -------------------------------------------------------------
   dcw_words_t   words_q;
   dcw_words_t   words_d;
   logic         valid_q;
   logic         valid_d;
   logic         reload_q;
   logic         reload_d;
   dcw_opts_t    opts;

   assign opts = decode_opts(words_q[DEV_OPT_INDEX]);

   always_comb begin
      words_d = words_q;
      valid_d = 1'b1;
      if (reload_q) begin
         words_d = NV_WORDS_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         // sample words while reset is held
         words_q <= NV_WORDS_IN;
         valid_q <= 1'b0;
      end else begin
         words_q <= words_d;
         valid_q <= valid_d;
      end
   end

   // -------------------------------------------------------------
   // wishbone slave
   // -------------------------------------------------------------
   logic         ack_q;
   logic         ack_d;
   logic [31:0]  rdat_q;
   logic [31:0]  rdat_d;
   logic         req;

   assign req = WB_CYC_IN && WB_STB_IN && !ack_q;

   always_comb begin
      ack_d    = req;
      rdat_d   = rdat_q;
      reload_d = 1'b0;
      if (req) begin
         rdat_d = DATA_ZERO;
         if (!WB_WE_IN) begin
            // user identifier readable with the rest of the word
            if (in_word_map(WB_ADR_IN)) begin
               rdat_d = words_q[word_index(WB_ADR_IN)];
            end else if (WB_ADR_IN == ADR_LOAD_STATUS) begin
               rdat_d[VALID_BIT] = valid_q;
            end
         end else if (WB_ADR_IN == ADR_RELOAD_CTRL && WB_SEL_IN[0]) begin
            reload_d = WB_DAT_IN[RELOAD_BIT];
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ack_q    <= 1'b0;
         rdat_q   <= DATA_ZERO;
         reload_q <= 1'b0;
      end else begin
         ack_q    <= ack_d;
         rdat_q   <= rdat_d;
         reload_q <= reload_d;
      end
   end

   assign WB_ACK_OUT = ack_q;
   assign WB_DAT_OUT = rdat_q;

   // -------------------------------------------------------------
   // pin input synchronisers
   // -------------------------------------------------------------
   logic         id_s1_q;
   logic         id_s2_q;
   dcw_i2c_rx_t  def_s1_q;
   dcw_i2c_rx_t  def_s2_q;
   dcw_i2c_rx_t  alt_s1_q;
   dcw_i2c_rx_t  alt_s2_q;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         id_s1_q  <= 1'b1;
         id_s2_q  <= 1'b1;
         def_s1_q <= '1;
         def_s2_q <= '1;
         alt_s1_q <= '1;
         alt_s2_q <= '1;
      end else begin
         id_s1_q  <= USB_ID_PIN_IN;
         id_s2_q  <= id_s1_q;
         def_s1_q <= DEF_PINS_IN;
         def_s2_q <= def_s1_q;
         alt_s1_q <= ALT_PINS_IN;
         alt_s2_q <= alt_s1_q;
      end
   end

   // -------------------------------------------------------------
   // pin ownership and routing
   // -------------------------------------------------------------
   localparam dcw_i2c_drv_t DRV_IDLE = '{data_out: 1'b0, data_oe: 1'b0,
                                          clk_out: 1'b0, clk_oe: 1'b0};
   logic          bus_pwr_q;
   logic          bus_pwr_d;
   logic          usb_id_q;
   logic          usb_id_d;
   logic          port_id_q;
   logic          port_id_d;
   dcw_i2c_drv_t  def_drv_q;
   dcw_i2c_drv_t  def_drv_d;
   dcw_i2c_drv_t  alt_drv_q;
   dcw_i2c_drv_t  alt_drv_d;
   dcw_i2c_rx_t   i2c_rx_q;
   dcw_i2c_rx_t   i2c_rx_d;
   logic          secondary_oscillator_hp_q;
   logic          secondary_oscillator_hp_d;

   always_comb begin
      bus_pwr_d = opts.bus_power_output_owner_sel ? USB_BUS_POWER_IN : PORT_BUS_POWER_IN;
      // identification pin owner; the other side sees an idle level
      usb_id_d  = opts.id_pin_owner_sel ? id_s2_q : 1'b1;
      port_id_d = opts.id_pin_owner_sel ? 1'b0 : id_s2_q;
      if (opts.i2c_location_sel) begin
         def_drv_d = I2C_DRV_IN;
         alt_drv_d = DRV_IDLE;
         i2c_rx_d  = def_s2_q;
      end else begin
         def_drv_d = DRV_IDLE;
         alt_drv_d = I2C_DRV_IN;
         i2c_rx_d  = alt_s2_q;
      end
      // clear bit asks for high power
      secondary_oscillator_hp_d = !opts.secondary_osc_power_sel;
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         bus_pwr_q <= 1'b0;
         usb_id_q  <= 1'b1;
         port_id_q <= 1'b0;
         def_drv_q <= DRV_IDLE;
         alt_drv_q <= DRV_IDLE;
         i2c_rx_q  <= '1;
         secondary_oscillator_hp_q <= 1'b0;
      end else begin
         bus_pwr_q <= bus_pwr_d;
         usb_id_q  <= usb_id_d;
         port_id_q <= port_id_d;
         def_drv_q <= def_drv_d;
         alt_drv_q <= alt_drv_d;
         i2c_rx_q  <= i2c_rx_d;
         secondary_oscillator_hp_q <= secondary_oscillator_hp_d;
      end
   end

   assign BUS_POWER_SWITCH_OUT = bus_pwr_q;
   assign USB_ID_OUT           = usb_id_q;
   assign PORT_ID_OUT          = port_id_q;
   assign DEF_PINS_OUT         = def_drv_q;
   assign ALT_PINS_OUT         = alt_drv_q;
   assign I2C_RX_OUT           = i2c_rx_q;
   assign SECONDARY_OSCILLATOR_HIGH_POWER_OUT  = secondary_oscillator_hp_q;
   // identifier exported as a plain value
   assign USER_ID_OUT          = opts.user_identifier;
   assign OPTS_VALID_OUT       = valid_q;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence s_word_read;
      WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !ack_q && WB_ADR_IN == ADR_ALT_DEV_OPT;
   endsequence

   a_user_id_read: assert property (
      s_word_read |=> WB_ACK_OUT && WB_DAT_OUT[USER_ID_LSB +: 16] == $past(USER_ID_OUT))
      else $error("user identifier read back wrong");

   a_bus_power_owner: assert property (
      $stable(opts) ##1 $stable(opts) |-> BUS_POWER_SWITCH_OUT ==
         $past(opts.bus_power_output_owner_sel ? USB_BUS_POWER_IN : PORT_BUS_POWER_IN))
      else $error("bus-power switch pin not driven by its owner");

   // the pin path restarts from idle at reset, so edges whose history reaches reset are skipped
   a_id_pin_owner: assert property (
      $stable(opts) [*3] ##0 !$past(RST_IN, 3) |->
         (opts.id_pin_owner_sel ? USB_ID_OUT == $past(USB_ID_PIN_IN, 3)
                                : PORT_ID_OUT == $past(USB_ID_PIN_IN, 3)))
      else $error("identification pin not routed to its owner");

   a_i2c_location: assert property (
      $stable(opts) ##1 ($stable(opts) && opts.i2c_location_sel) |->
         DEF_PINS_OUT == $past(I2C_DRV_IN) && !ALT_PINS_OUT.data_oe && !ALT_PINS_OUT.clk_oe)
      else $error("first I2C port not on its default pins");

   a_i2c_alternate: assert property (
      $stable(opts) ##1 ($stable(opts) && !opts.i2c_location_sel) |->
         ALT_PINS_OUT == $past(I2C_DRV_IN) && !DEF_PINS_OUT.data_oe && !DEF_PINS_OUT.clk_oe)
      else $error("first I2C port not on its alternate pins");

   a_secondary_oscillator_power: assert property (
      $stable(opts) ##1 $stable(opts) |-> SECONDARY_OSCILLATOR_HIGH_POWER_OUT == !opts.secondary_osc_power_sel)
      else $error("secondary oscillator power mode wrong");

   a_words_hold: assert property (
      !reload_q |=> $stable(words_q))
      else $error("configuration words changed without a reload");

   a_write_ignored: assert property (
      WB_CYC_IN && WB_STB_IN && WB_WE_IN && !ack_q && in_word_map(WB_ADR_IN)
      |=> WB_ACK_OUT ##1 words_q == $past(words_q, 2))
      else $error("bus write altered a configuration word");

   a_reload_load: assert property (
      reload_q |=> words_q == $past(NV_WORDS_IN) && OPTS_VALID_OUT)
      else $error("reload did not take the stored words");

endmodule

/* File: design/dcw_pkg.sv */
// constants, field layout and carrier types of the device-options configuration loader
package dcw_pkg;

   // -------------------------------------------------------------
   // word map (byte addresses)
   // -------------------------------------------------------------
   localparam int unsigned NUM_WORDS          = 10;
   localparam logic [15:0] ADR_ALT_RSVD_A     = 16'h1740;
   localparam logic [15:0] ADR_ALT_DEV_OPT    = 16'h1744;
   localparam logic [15:0] ADR_ALT_DEBUG      = 16'h1748;
   localparam logic [15:0] ADR_ALT_POWER_UP   = 16'h174C;
   localparam logic [15:0] ADR_ALT_WATCHDOG   = 16'h1750;
   localparam logic [15:0] ADR_ALT_OSC_SEL    = 16'h1754;
   localparam logic [15:0] ADR_ALT_CODE_PROT  = 16'h1758;
   localparam logic [15:0] ADR_ALT_RSVD_B     = 16'h175C;
   localparam logic [15:0] ADR_ALT_RSVD_C     = 16'h1760;
   localparam logic [15:0] ADR_ALT_RSVD_D     = 16'h1764;
   localparam logic [15:0] ADR_RELOAD_CTRL    = 16'h1780;
   localparam logic [15:0] ADR_LOAD_STATUS    = 16'h1784;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int unsigned DEV_OPT_INDEX      = 1;
   localparam int unsigned USER_ID_LSB        = 16;
   localparam int unsigned BUS_PWR_SEL_BIT    = 15;
   localparam int unsigned ID_PIN_SEL_BIT     = 14;
   localparam int unsigned I2C_LOC_SEL_BIT    = 4;
   localparam int unsigned SECONDARY_OSCILLATOR_PWR_SEL_BIT   = 3;
   localparam int unsigned RELOAD_BIT         = 0;
   localparam int unsigned VALID_BIT          = 0;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [31:0] WORD_RESET         = 32'hFFFFFFFF;
   localparam logic [31:0] DATA_ZERO          = 32'h00000000;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef logic [NUM_WORDS-1:0][31:0] dcw_words_t;

   typedef struct packed {
      logic [15:0] user_identifier;
      logic        bus_power_output_owner_sel;
      logic        id_pin_owner_sel;
      logic        i2c_location_sel;
      logic        secondary_osc_power_sel;
   } dcw_opts_t;

   // drive side of an open-drain line pair: level and enable per line
   typedef struct packed {
      logic data_out;
      logic data_oe;
      logic clk_out;
      logic clk_oe;
   } dcw_i2c_drv_t;

   // receive side of a line pair
   typedef struct packed {
      logic data_in;
      logic clk_in;
   } dcw_i2c_rx_t;

   // fields of the device-options word
   function automatic dcw_opts_t decode_opts(input logic [31:0] w);
      dcw_opts_t o;
      o.user_identifier            = w[USER_ID_LSB +: 16];
      o.bus_power_output_owner_sel = w[BUS_PWR_SEL_BIT];
      o.id_pin_owner_sel           = w[ID_PIN_SEL_BIT];
      o.i2c_location_sel           = w[I2C_LOC_SEL_BIT];
      o.secondary_osc_power_sel    = w[SECONDARY_OSCILLATOR_PWR_SEL_BIT];
      return o;
   endfunction

   // word slot of a byte address inside the alternate word map
   function automatic logic [3:0] word_index(input logic [15:0] adr);
      logic [15:0] off;
      off = adr - ADR_ALT_RSVD_A;
      return off[5:2];
   endfunction

   function automatic logic in_word_map(input logic [15:0] adr);
      return (adr >= ADR_ALT_RSVD_A) && (adr <= ADR_ALT_RSVD_D) && (adr[1:0] == 2'h0);
   endfunction

endpackage

/* File: verif/dcw_config_loader_tb_top.sv */
// self-checking bench of the device-options configuration loader
`timescale 1ns/1ps
module dcw_config_loader_tb_top;
   import dcw_pkg::*;

   // -------------------------------------------------------------
   // stimulus and observed signals
   // -------------------------------------------------------------
   logic          clk_in;
   logic          rst_in;
   logic          cyc;
   logic          stb;
   logic          we;
   logic [15:0]   adr;
   logic [3:0]    sel;
   logic [31:0]   wdat;
   logic [31:0]   rdat;
   logic          ack;
   dcw_words_t    words;
   logic          usb_bp;
   logic          port_bp;
   logic          bp_out;
   logic          id_pin;
   logic          usb_id;
   logic          port_id;
   dcw_i2c_drv_t  drv;
   dcw_i2c_rx_t   rx;
   dcw_i2c_rx_t   def_in;
   dcw_i2c_rx_t   alt_in;
   dcw_i2c_drv_t  def_out;
   dcw_i2c_drv_t  alt_out;
   logic [15:0]   uid_out;
   logic          hp_out;
   logic          valid_out;
   int            err_count;
   int            check_count;

   dcw_config_loader i_dut (
      .CLK_IN(clk_in), .RST_IN(rst_in), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .NV_WORDS_IN(words),
      .USB_BUS_POWER_IN(usb_bp), .PORT_BUS_POWER_IN(port_bp),
      .BUS_POWER_SWITCH_OUT(bp_out), .USB_ID_PIN_IN(id_pin), .USB_ID_OUT(usb_id),
      .PORT_ID_OUT(port_id), .I2C_DRV_IN(drv), .I2C_RX_OUT(rx), .DEF_PINS_IN(def_in),
      .DEF_PINS_OUT(def_out), .ALT_PINS_IN(alt_in), .ALT_PINS_OUT(alt_out),
      .USER_ID_OUT(uid_out), .SECONDARY_OSCILLATOR_HIGH_POWER_OUT(hp_out), .OPTS_VALID_OUT(valid_out)
   );

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // classic single cycle, entered just after a rising edge
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'h1 && n < 50);
      if (n >= 50) begin
         err_count++;
      end
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      @(posedge clk_in);
   endtask

   // reserved spans programmed as ones
   // reserved ones
   function automatic logic [31:0] opt_word(input logic s, input logic [15:0] u);
      return {u, s, s, 9'h1FF, s, s, 3'h7};
   endfunction

   task automatic reload(input logic [31:0] w);
      logic [31:0] q;
      words[DEV_OPT_INDEX] <= w;
      @(posedge clk_in);
      wb(1'h1, ADR_RELOAD_CTRL, 32'h1, q);
      repeat (4) @(posedge clk_in);
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_map;
      logic [31:0] q;
      for (int i = 0; i < NUM_WORDS; i++) begin
         wb(1'h0, ADR_ALT_RSVD_A + 16'(4 * i), 32'h0, q);
         chk("word read", words[i], q);
      end
      wb(1'h1, ADR_ALT_DEV_OPT, 32'h0, q);
      wb(1'h0, ADR_ALT_DEV_OPT, 32'h0, q);
      chk("word after write", words[DEV_OPT_INDEX], q);
      wb(1'h0, 16'h1790, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      wb(1'h0, ADR_LOAD_STATUS, 32'h0, q);
      chk("load status", 32'h1, q);
      wb(1'h0, ADR_RELOAD_CTRL, 32'h0, q);
      chk("reload control", 32'h0, q);
      // new stored word unseen before reload
      words[DEV_OPT_INDEX] <= opt_word(1'h0, 16'h0F0F);
      wb(1'h0, ADR_ALT_DEV_OPT, 32'h0, q);
      chk("word before reload", opt_word(1'h1, 16'h3C5A), q);
      chk("user id before reload", 16'h3C5A, uid_out);
   endtask

   task automatic t_pins;
      logic s;
      logic p;
      logic [3:0] dv;
      for (int k = 0; k < 4; k++) begin
         s = k[0];
         p = k[1];
         dv = {p, 1'h1, ~p, 1'h1};
         usb_bp <= p;
         port_bp <= ~p;
         id_pin <= p;
         drv <= dv;
         def_in <= 2'h1;
         alt_in <= 2'h2;
         reload(opt_word(s, 16'hA5C0 + 16'(k)));
         chk("bus power pin", s ? p : !p, bp_out);
         chk("usb id level", s ? p : 1'h1, usb_id);
         chk("port id level", s ? 1'h0 : p, port_id);
         chk("default pair", s ? dv : 4'h0, def_out);
         chk("alternate pair", s ? 4'h0 : dv, alt_out);
         chk("i2c receive", s ? 2'h1 : 2'h2, rx);
         chk("secondary_oscillator high power", !s, hp_out);
         chk("user id", 16'hA5C0 + 16'(k), uid_out);
      end
   endtask

   // -------------------------------------------------------------
   // clock, main sequence, watchdog
   // -------------------------------------------------------------
   initial begin
      clk_in = 1'h0;
      forever #10 clk_in = ~clk_in;
   end

   initial begin
      err_count = 0;
      check_count = 0;
      rst_in = 1'h1;
      {cyc, stb, we, adr, sel, wdat} = '0;
      {usb_bp, port_bp, id_pin, drv, def_in, alt_in} = '0;
      for (int i = 0; i < NUM_WORDS; i++) begin
         words[i] = (i == 8) ? 32'h7FFFFFFF : 32'hFFFFFFFF;
      end
      words[DEV_OPT_INDEX] = opt_word(1'h1, 16'h3C5A);
      repeat (16) @(posedge clk_in);
      chk("valid in reset", 32'h0, valid_out);
      rst_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      chk("valid after reset", 32'h1, valid_out);
      chk("user id at load", 16'h3C5A, uid_out);
      t_map();
      t_pins();
      tally_and_finish();
   end

   initial begin
      #400000;
      err_count++;
      tally_and_finish();
   end
endmodule
